//--- verilog/pin_select_map.svh
/*
 * register indices, field positions, reset values for the port pin
 * function select block. assumes an apb slave where byte address = index*4.
 */
`ifndef PIN_SELECT_MAP_SVH
`define PIN_SELECT_MAP_SVH

`define SERIAL_SEL_IDX 16'hff20
`define ANALOG_CFG_IDX 16'hff8f
`define SEG_TWO_IDX 16'hffb5
`define SEG_ONE_IDX 16'hffb6
`define PORT_DATA_IDX 16'hff02
`define PORT_DIR_IDX 16'hff22
`define PORT_BITOP_IDX 16'hff40

`define TX_ROUTE_POS 3
`define BITOP_VALUE_POS 3
`define SEG_ONE_MASK 8'h6c
`define SERIAL_SEL_RESET 1'h0
`define SEG_TWO_RESET 6'h00
`define SEG_ONE_RESET 4'h0
`define ANALOG_CFG_RESET 4'h8
`define ANALOG_PROHIBITED 3'h7

`endif

//--- verilog/pin_select_pkg.sv
/*
 * types shared by the port pin function select block.
 * assumes pin_select_map.svh supplies the numeric constants.
 */
package pin_select_pkg;

    typedef enum logic [2:0] {
        sel_none,
        sel_serial,
        sel_analog,
        sel_seg_two,
        sel_seg_one,
        sel_data,
        sel_dir,
        sel_bitop
    } reg_sel_e;

    typedef struct packed {
        logic [17:0] addr;
        logic write;
        logic [31:0] wdata;
    } apb_req_s;

endpackage

//--- verilog/port_pin_function_select.sv
/*
 * port pin function select and port two data path, apb register slave.
 * assumes one clock pclk, async active-low presetn, pins from outside.
 */
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
`include "pin_select_map.svh"

module port_pin_function_select
    import pin_select_pkg::*;
#(
    parameter int PORT_W = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [PORT_W-1:0] pin_in,
    output logic [PORT_W-1:0] pin_out,
    output logic [PORT_W-1:0] pin_oe,
    output logic [PORT_W-1:0] seg_two_enable,
    output logic [3:0] seg_one_enable,
    output logic [PORT_W-1:0] analog_enable,
    output logic transmit_route,
    output logic key_input_enable
);

////////////////////////////////////////////////////////////////////////////////
// address decode

    function automatic reg_sel_e decode(input logic [17:0] a);
        if (a == {`SERIAL_SEL_IDX, 2'b00}) begin
            return sel_serial;
        end else if (a == {`ANALOG_CFG_IDX, 2'b00}) begin
            return sel_analog;
        end else if (a == {`SEG_TWO_IDX, 2'b00}) begin
            return sel_seg_two;
        end else if (a == {`SEG_ONE_IDX, 2'b00}) begin
            return sel_seg_one;
        end else if (a == {`PORT_DATA_IDX, 2'b00}) begin
            return sel_data;
        end else if (a == {`PORT_DIR_IDX, 2'b00}) begin
            return sel_dir;
        end else if (a == {`PORT_BITOP_IDX, 2'b00}) begin
            return sel_bitop;
        end else begin
            return sel_none;
        end
    endfunction

    apb_req_s req;
    reg_sel_e sel;
    logic setup;
    logic done;
    logic wr;

    assign req = '{addr: paddr, write: pwrite, wdata: pwdata};
    assign sel = decode(req.addr);
    assign setup = psel && !penable;
    assign done = psel && penable && pready;
    assign wr = done && req.write;

////////////////////////////////////////////////////////////////////////////////
// registers

    logic serial_sel;
    logic [PORT_W-1:0] seg_two;
    logic [3:0] seg_one;
    logic [3:0] analog_cfg;
    logic [PORT_W-1:0] out_latch;
    logic [PORT_W-1:0] dir_in;
    logic [PORT_W-1:0] pin_meta;
    logic [PORT_W-1:0] pin_sync;
    logic [PORT_W-1:0] view;
    logic [PORT_W-1:0] next_bitop;
    logic [2:0] bit_num;

    assign bit_num = req.wdata[2:0];

    // bit or byte writes both arrive as full words, so one path serves both
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_sel <= `SERIAL_SEL_RESET;
            seg_two <= `SEG_TWO_RESET;
            seg_one <= `SEG_ONE_RESET;
            analog_cfg <= `ANALOG_CFG_RESET;
        end else if (wr) begin
            if (sel == sel_serial) begin
                serial_sel <= req.wdata[`TX_ROUTE_POS];
            end else if (sel == sel_seg_two) begin
                seg_two <= req.wdata[PORT_W-1:0];
            end else if (sel == sel_seg_one) begin
                seg_one <= {req.wdata[6], req.wdata[5], req.wdata[3], req.wdata[2]};
            end else if (sel == sel_analog) begin
                // bit 3 only holds its reset one until the first write
                analog_cfg <= {1'b0, req.wdata[2:0]};
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_in <= '1;
        end else if (wr && sel == sel_dir) begin
            dir_in <= req.wdata[PORT_W-1:0];
        end
    end

    // two flops before anything reads the pins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_meta <= '0;
            pin_sync <= '0;
        end else begin
            pin_meta <= pin_in;
            pin_sync <= pin_meta;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// port data path

    genvar gi;
    generate
        for (gi = 0; gi < PORT_W; gi++) begin : g_view
            assign view[gi] = dir_in[gi] ? pin_sync[gi] : out_latch[gi];
        end
    endgenerate

    // input pins take their pin level into the latch: the whole port is rewritten
    always_comb begin
        next_bitop = view;
        if (32'(bit_num) < PORT_W) begin
            next_bitop[bit_num] = req.wdata[`BITOP_VALUE_POS];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_latch <= '0;
        end else if (wr && sel == sel_data) begin
            out_latch <= req.wdata[PORT_W-1:0];
        end else if (wr && sel == sel_bitop) begin
            out_latch <= next_bitop;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// pin function outputs

    logic [PORT_W-1:0] analog_sel;
    logic [PORT_W-1:0] drive_sel;

    generate
        for (gi = 0; gi < PORT_W; gi++) begin : g_func
            // prohibited code 7 is taken as all digital: no pin floats analog
            assign analog_sel[gi] = !seg_two[gi]
                && analog_cfg[2:0] != `ANALOG_PROHIBITED
                && 32'(analog_cfg[2:0]) <= gi;
            assign drive_sel[gi] = !dir_in[gi] && !seg_two[gi] && !analog_sel[gi];
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out <= '0;
            pin_oe <= '0;
            seg_two_enable <= '0;
            seg_one_enable <= '0;
            analog_enable <= '0;
            transmit_route <= 1'b0;
            key_input_enable <= 1'b1;
        end else begin
            pin_out <= out_latch;
            pin_oe <= drive_sel;
            seg_two_enable <= seg_two;
            seg_one_enable <= seg_one;
            analog_enable <= analog_sel;
            transmit_route <= serial_sel;
            key_input_enable <= !serial_sel;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// apb answer

    logic [31:0] read_value;

    always_comb begin
        read_value = '0;
        if (sel == sel_serial) begin
            read_value[`TX_ROUTE_POS] = serial_sel;
        end else if (sel == sel_analog) begin
            read_value[3:0] = analog_cfg;
        end else if (sel == sel_seg_two) begin
            read_value[PORT_W-1:0] = seg_two;
        end else if (sel == sel_seg_one) begin
            read_value[6:5] = seg_one[3:2];
            read_value[3:2] = seg_one[1:0];
        end else if (sel == sel_data) begin
            read_value[PORT_W-1:0] = view;
        end else if (sel == sel_dir) begin
            read_value[PORT_W-1:0] = dir_in;
        end
    end

    // data is taken at setup so the access cycle answers with no wait, except on an analog config write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pslverr <= 1'b0;
        end else if (setup) begin
            prdata <= req.write ? 32'h0 : read_value;
            pslverr <= sel == sel_none;
        end else if (done) begin
            pslverr <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
        end else if (setup) begin
            pready <= !(req.write && sel == sel_analog);
        end else if (psel && penable && !pready) begin
            pready <= 1'b1;
        end else begin
            pready <= 1'b0;
        end
    end

////////////////////////////////////////////////////////////////////////////////
// checks

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence analog_write_setup;
        setup && req.write && sel == sel_analog;
    endsequence

    sequence one_wait_then_ready;
        psel && penable && !pready ##1 psel && penable && pready;
    endsequence

    a_analog_wait_state: assert property (
        analog_write_setup |=> one_wait_then_ready)
        else $error("analog config write lacks one wait cycle");

    a_other_no_wait: assert property (
        setup && !(req.write && sel == sel_analog) |=> pready)
        else $error("access other than analog write was stalled");

    a_serial_zero_bits: assert property (
        done && !req.write && sel == sel_serial |-> (prdata & ~32'h8) == 32'h0)
        else $error("serial select fixed bits read nonzero");

    a_seg_one_bits: assert property (
        done && !req.write && sel == sel_seg_one |-> prdata[7:0] == (prdata[7:0] & `SEG_ONE_MASK)
        && prdata[31:8] == 24'h0)
        else $error("port one segment select unused bits nonzero");

    a_route_follows: assert property (
        wr && sel == sel_serial |-> ##2 transmit_route == $past(req.wdata[3], 2)
        && key_input_enable == !transmit_route)
        else $error("transmit route not taken from written bit");

    a_seg_wins_analog: assert property (
        (seg_two_enable & analog_enable) == '0)
        else $error("segment pin also marked analog");

    a_all_digital: assert property (
        wr && sel == sel_analog && req.wdata[2:0] == 3'h6 |-> ##2 analog_enable == '0)
        else $error("field six left an analog pin");

    a_input_undriven: assert property (
        1'b1 |=> (pin_oe & $past(dir_in)) == '0)
        else $error("input mode pin driven");

    a_read_keeps_latch: assert property (
        done && !req.write |=> out_latch == $past(out_latch))
        else $error("port read changed the output latch");

    a_write_sets_latch: assert property (
        wr && sel == sel_data |=> out_latch == $past(req.wdata[PORT_W-1:0]) ##1 pin_out == $past(out_latch))
        else $error("port write not latched and driven");

endmodule

//--- testbench/port_pin_function_select_tb.sv
/*
 * self-checking bench for port_pin_function_select: apb master tasks and scenarios.
 * assumes the register map header is on the include path and pins are driven here.
 */
`timescale 1ns/100ps
`include "pin_select_map.svh"

module port_pin_function_select_tb;

////////////////////////////////////////////////////////////////////////////////
logic pclk = 1'b0;
logic presetn = 1'b0;
logic psel = 1'b0;
logic penable = 1'b0;
logic pwrite = 1'b0;
logic [17:0] paddr = 18'h00000;
logic [31:0] pwdata = 32'h00000000;
logic [31:0] prdata;
logic pready;
logic pslverr;
logic [5:0] pin_in = 6'h00;
logic [5:0] pin_out;
logic [5:0] pin_oe;
logic [5:0] seg_two_enable;
logic [3:0] seg_one_enable;
logic [5:0] analog_enable;
logic transmit_route;
logic key_input_enable;
int bad_count = 0;
int comparisons = 0;
int cycles = 0;
int waits;
logic [31:0] rdat;
logic err;

port_pin_function_select #(.PORT_W(6)) u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .seg_two_enable(seg_two_enable), .seg_one_enable(seg_one_enable),
    .analog_enable(analog_enable), .transmit_route(transmit_route),
    .key_input_enable(key_input_enable)
);

always #20 pclk = ~pclk;

////////////////////////////////////////////////////////////////////////////////
task final_report;
    $display("tests done: %0d comparisons, %0d mismatches", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
        $display("No errors found");
    end else begin
        $display("Errors were found");
    end
    $finish;
endtask

// ceiling is far above the few hundred cycles the scenarios need
always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
        bad_count = bad_count + 1;
        final_report();
    end
end

task check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons = comparisons + 1;
    if (seen !== exp) begin
        bad_count = bad_count + 1;
        $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask

// pready is read right after the edge, so it is the value sampled at that edge
task apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    waits = 0;
    forever begin
        @(posedge pclk);
        if (pready === 1'b1) break;
        waits = waits + 1;
    end
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask

// outputs lag the register by one clock; three edges leave margin for the pin sync
task settle;
    repeat (3) @(posedge pclk);
endtask

////////////////////////////////////////////////////////////////////////////////
task t_reset;
    apb(1'b0, `SERIAL_SEL_IDX, 0); check(rdat, 32'h00);
    apb(1'b0, `ANALOG_CFG_IDX, 0); check(rdat, 32'h08);
    apb(1'b0, `SEG_TWO_IDX, 0); check(rdat, 32'h00);
    apb(1'b0, `SEG_ONE_IDX, 0); check(rdat, 32'h00);
    check({transmit_route, key_input_enable, seg_one_enable, seg_two_enable}, 32'h400);
    check({pin_out, pin_oe}, 32'h0);
    $display("test reset values done");
endtask

task t_select;
    apb(1'b1, `SERIAL_SEL_IDX, 32'hffffffff); check(32'(waits), 32'h0);
    settle();
    apb(1'b0, `SERIAL_SEL_IDX, 0); check(rdat, 32'h08);
    check({transmit_route, key_input_enable}, 32'h2);
    apb(1'b1, `SERIAL_SEL_IDX, 32'h00); settle();
    check({transmit_route, key_input_enable}, 32'h1);
    apb(1'b1, `SEG_TWO_IDX, 32'hff); settle();
    apb(1'b0, `SEG_TWO_IDX, 0); check(rdat, 32'h3f);
    check(seg_two_enable, 32'h3f);
    apb(1'b1, `SEG_ONE_IDX, 32'hff); settle();
    apb(1'b0, `SEG_ONE_IDX, 0); check(rdat, 32'h6c);
    check(seg_one_enable, 32'hf);
    apb(1'b1, `SEG_ONE_IDX, 32'h24); settle();
    check(seg_one_enable, 32'h5);
    apb(1'b1, `SEG_TWO_IDX, 32'h00);
    apb(1'b1, `SEG_ONE_IDX, 32'h00); settle();
    check({seg_one_enable, seg_two_enable}, 32'h0);
    $display("test select registers done");
endtask

task t_analog;
    logic [5:0] m;
    // analog pins stay in input mode, the clock never stops, no channel is selected
    apb(1'b1, `PORT_DIR_IDX, 32'h3f);
    for (int k = 0; k < 7; k++) begin
        apb(1'b1, `ANALOG_CFG_IDX, 32'(k)); check(32'(waits), 32'h1);
        settle();
        apb(1'b0, `ANALOG_CFG_IDX, 0); check(rdat, 32'(k));
        m = 6'h3f << k;
        check(analog_enable, 32'(m));
    end
    apb(1'b1, `ANALOG_CFG_IDX, 32'h0);
    apb(1'b1, `SEG_TWO_IDX, 32'h21); settle();
    check(analog_enable, 32'h1e);
    check(seg_two_enable, 32'h21);
    apb(1'b1, `SEG_TWO_IDX, 32'h00);
    apb(1'b1, `ANALOG_CFG_IDX, 32'hff); settle();
    apb(1'b0, `ANALOG_CFG_IDX, 0); check(rdat, 32'h07);
    check(analog_enable, 32'h0);
    apb(1'b1, `ANALOG_CFG_IDX, 32'h6); settle();
    $display("test analog config done");
endtask

task t_port;
    apb(1'b1, `PORT_DIR_IDX, 32'h00);
    apb(1'b1, `PORT_DATA_IDX, 32'h15); settle();
    check({pin_out, pin_oe}, 32'h57f);
    apb(1'b0, `PORT_DATA_IDX, 0); check(rdat, 32'h15);
    apb(1'b1, `PORT_DIR_IDX, 32'h3f);
    apb(1'b1, `PORT_DATA_IDX, 32'h2a);
    pin_in <= 6'h0c; settle();
    check(pin_oe, 32'h0);
    apb(1'b0, `PORT_DATA_IDX, 0); check(rdat, 32'h0c);
    apb(1'b1, `PORT_DIR_IDX, 32'h00); settle();
    check({pin_out, pin_oe}, 32'habf);
    apb(1'b0, `PORT_DATA_IDX, 0); check(rdat, 32'h2a);
    $display("test port data path done");
endtask

task t_bitop;
    apb(1'b1, `PORT_DIR_IDX, 32'h3f);
    apb(1'b1, `PORT_DATA_IDX, 32'h00);
    pin_in <= 6'h2a; settle();
    apb(1'b1, `PORT_BITOP_IDX, 32'h08); settle();
    check(pin_oe, 32'h0);
    apb(1'b1, `PORT_DIR_IDX, 32'h00); settle();
    apb(1'b0, `PORT_DATA_IDX, 0); check(rdat, 32'h2b);
    pin_in <= 6'h00;
    apb(1'b1, `PORT_BITOP_IDX, 32'h01); settle();
    apb(1'b0, `PORT_DATA_IDX, 0); check(rdat, 32'h29);
    check(pin_out, 32'h29);
    $display("test bit operations done");
endtask

task t_unmapped;
    apb(1'b1, 16'hff00, 32'hff);
    check({31'h0, err}, 32'h1);
    apb(1'b0, 16'hff00, 0); check(rdat, 32'h0);
    $display("test unmapped address done");
endtask

////////////////////////////////////////////////////////////////////////////////
initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_select();
    t_analog();
    t_port();
    t_bitop();
    t_unmapped();
    final_report();
end

endmodule
